// *** pcint_pkg.sv ***
/*
  pcint_pkg: constants and carrier types for the pin-change interrupt block.
  Assumes an 8-bit register port with word-free byte offsets of its own choosing.
*/
package pcint_pkg;
  localparam int unsigned NPINS = 6;
  localparam int unsigned DW    = 8;
  localparam int unsigned AW    = 4;

  localparam logic [AW-1:0] OFS_RISE   = 4'h0;
  localparam logic [AW-1:0] OFS_FALL   = 4'h1;
  localparam logic [AW-1:0] OFS_FLAGS  = 4'h2;
  localparam logic [AW-1:0] OFS_INTCTL = 4'h3;
  localparam logic [AW-1:0] OFS_IRQST  = 4'h4;
  localparam logic [AW-1:0] OFS_IRQMSK = 4'h5;

  localparam logic [NPINS-1:0] PIN_RST = 6'h00;
  localparam logic [DW-1:0]    RD_ZERO = 8'h00;

  localparam int unsigned BIT_MASTER_EN = 0;
  localparam int unsigned BIT_SUMMARY   = 1;
  localparam int unsigned BIT_SLEEP     = 2;

  localparam int unsigned EV_EDGE  = 0;
  localparam int unsigned EV_WAKE  = 1;
  localparam int unsigned NEV      = 2;
  localparam logic [NEV-1:0] EV_RST = 2'h0;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pcint_req_t;
endpackage

// *** pcint_top.sv ***
/*
  pcint_top: pin-change detection with per-pin rise/fall enables, sticky flags,
  summary flag, master enable, interrupt request and wake-from-sleep.
  Assumes one clock clk_sys, async active-high rst, pins asynchronous to clk_sys.
*/
// Behaviour
// - a rising edge on a pin is detected only while its rise-enable bit is set.
// - a falling edge on a pin is detected only while its fall-enable bit is set.
// - with both enables set, edges of either polarity are detected on that pin.
// - an enabled detected edge sets the pin's change flag to one.
// - flags keep setting with the master enable clear, but cpu_irq is requested only with it set; irq_out follows the event status and mask alone.
// - the summary flag is the OR of all six change flags.
// - software clears a change flag by writing zero to its bit, and hardware can still set it.
// - an edge detected during a flag write leaves that flag set whatever was written.
// - with the master enable set, any enabled edge wakes the device from sleep.
// - an edge seen during sleep reaches the flag register on the same clock edge as the wake output rises.
// - only bits 5 to 0 of the enable and flag registers exist; bits 7 and 6 read zero.
`timescale 1ns/1ps
`default_nettype none
module pcint_top #(
  parameter int unsigned NP = pcint_pkg::NPINS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire pcint_pkg::pcint_req_t req,
  output logic [pcint_pkg::DW-1:0]  rdata,
  input  wire logic [NP-1:0]        port_pins,
  input  wire logic                 sleep_mode,
  output logic                      cpu_irq,
  output logic                      wake_up,
  output logic                      change_int_summary_flag,
  output logic                      irq_out
);
  import pcint_pkg::*;

  logic [NP-1:0]  sync1_r;
  logic [NP-1:0]  sync2_r;
  logic [NP-1:0]  prev_r;
  logic [NP-1:0]  rise_edge_enable_r;
  logic [NP-1:0]  fall_edge_enable_r;
  logic [NP-1:0]  pin_change_flags_r;
  logic [NP-1:0]  pin_change_flags_nxt;
  logic           change_int_master_enable_r;
  logic [NEV-1:0] ev_status_r;
  logic [NEV-1:0] ev_mask_r;
  logic [NP-1:0]  rise_det;
  logic [NP-1:0]  fall_det;
  logic [NP-1:0]  pin_change_detect;
  logic           wr_flags;
  logic           sleep_s1_r;
  logic           sleep_s2_r;
  logic [NEV-1:0] ev_now;

  function automatic logic [DW-1:0] pad(input logic [NP-1:0] v);
    pad = {{(DW-NP){1'b0}}, v};
  endfunction

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // two-flop synchronisers; sync1_r read only by sync2_r
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= PIN_RST;
      sync2_r <= PIN_RST;
      prev_r  <= PIN_RST;
    end else begin
      sync1_r <= port_pins;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= sleep_mode;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  assign rise_det = sync2_r & ~prev_r & rise_edge_enable_r;
  assign fall_det = ~sync2_r & prev_r & fall_edge_enable_r;
  assign pin_change_detect = rise_det | fall_det;
  assign wr_flags = req.wr && hit(req.addr, OFS_FLAGS);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rise_edge_enable_r <= PIN_RST;
      fall_edge_enable_r <= PIN_RST;
      change_int_master_enable_r <= 1'b0;
      ev_mask_r <= EV_RST;
    end else if (req.wr) begin
      if (hit(req.addr, OFS_RISE)) begin
        rise_edge_enable_r <= req.wdata[NP-1:0];
      end
      if (hit(req.addr, OFS_FALL)) begin
        fall_edge_enable_r <= req.wdata[NP-1:0];
      end
      if (hit(req.addr, OFS_INTCTL)) begin
        change_int_master_enable_r <= req.wdata[BIT_MASTER_EN];
      end
      if (hit(req.addr, OFS_IRQMSK)) begin
        ev_mask_r <= req.wdata[NEV-1:0];
      end
    end
  end

  always_comb begin
    pin_change_flags_nxt = pin_change_flags_r;
    if (wr_flags) begin
      pin_change_flags_nxt = pin_change_flags_r & req.wdata[NP-1:0];
    end
    pin_change_flags_nxt = pin_change_flags_nxt | pin_change_detect;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_change_flags_r <= PIN_RST;
    end else begin
      pin_change_flags_r <= pin_change_flags_nxt;
    end
  end

  // sticky event status: edge seen, wake raised; set wins over write-one-clear
  assign ev_now[EV_EDGE] = |pin_change_detect;
  assign ev_now[EV_WAKE] = change_int_master_enable_r && sleep_s2_r && (|pin_change_detect);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_status_r <= EV_RST;
    end else if (req.wr && hit(req.addr, OFS_IRQST)) begin
      ev_status_r <= (ev_status_r & ~req.wdata[NEV-1:0]) | ev_now;
    end else begin
      ev_status_r <= ev_status_r | ev_now;
    end
  end

  // outputs registered from next-state so flags and requests move together
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      change_int_summary_flag <= 1'b0;
      cpu_irq <= 1'b0;
      wake_up <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      change_int_summary_flag <= |pin_change_flags_nxt;
      cpu_irq <= change_int_master_enable_r && (|pin_change_flags_nxt);
      // flags already hold the edge when wake rises
      wake_up <= change_int_master_enable_r && sleep_s2_r && (|pin_change_flags_nxt);
      irq_out <= |((ev_status_r | ev_now) & ev_mask_r);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= RD_ZERO;
    end else if (req.rd) begin
      case (req.addr)
        OFS_RISE:   rdata <= pad(rise_edge_enable_r);
        OFS_FALL:   rdata <= pad(fall_edge_enable_r);
        OFS_FLAGS:  rdata <= pad(pin_change_flags_r);
        OFS_INTCTL: begin
          rdata <= RD_ZERO;
          rdata[BIT_MASTER_EN] <= change_int_master_enable_r;
          rdata[BIT_SUMMARY]   <= |pin_change_flags_r;
          rdata[BIT_SLEEP]     <= sleep_s2_r;
        end
        OFS_IRQST:  rdata <= {{(DW-NEV){1'b0}}, ev_status_r};
        OFS_IRQMSK: rdata <= {{(DW-NEV){1'b0}}, ev_mask_r};
        default:    rdata <= RD_ZERO;
      endcase
    end else begin
      rdata <= RD_ZERO;
    end
  end

  sequence edge_seen_s;
    |pin_change_detect;
  endsequence

  rise_sets_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sync2_r[0] && !prev_r[0] && rise_edge_enable_r[0]) |=> pin_change_flags_r[0])
    else $error("enabled rise did not set flag");
  fall_sets_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!sync2_r[0] && prev_r[0] && fall_edge_enable_r[0]) |=> pin_change_flags_r[0])
    else $error("enabled fall did not set flag");
  no_enable_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rise_edge_enable_r == PIN_RST && fall_edge_enable_r == PIN_RST) |-> pin_change_detect == PIN_RST)
    else $error("edge detected with enables clear");
  flag_source_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(pin_change_flags_r[0]) |-> $past(pin_change_detect[0]))
    else $error("flag rose without detection");
  irq_gated_a: assert property (@(posedge clk_sys) disable iff (rst)
    cpu_irq |-> $past(change_int_master_enable_r))
    else $error("interrupt without master enable");
  summary_or_a: assert property (@(posedge clk_sys) disable iff (rst)
    change_int_summary_flag == (|pin_change_flags_r))
    else $error("summary not OR of flags");
  write_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_flags && req.wdata[0] == 1'b0 && !pin_change_detect[0]) |=> !pin_change_flags_r[0])
    else $error("flag not cleared by zero write");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_flags && pin_change_detect[0]) |=> pin_change_flags_r[0])
    else $error("edge lost during flag write");
  sequence sleep_armed_s;
    change_int_master_enable_r && sleep_s2_r;
  endsequence

  sequence flag_write_s;
    wr_flags;
  endsequence

  wake_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sleep_armed_s ##0 edge_seen_s) |=> wake_up)
    else $error("no wake on enabled edge");
  wake_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
    wake_up |-> change_int_summary_flag)
    else $error("wake before flags updated");
  upper_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && req.addr <= OFS_FLAGS) |-> rdata[DW-1:NP] == 2'h0)
    else $error("unimplemented bits read nonzero");
  pulse_one_a: assert property (@(posedge clk_sys) disable iff (rst)
    rise_det[0] |=> !rise_det[0])
    else $error("detection longer than one cycle");

  // whole-port checks
  rise_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sync2_r & ~prev_r & ~rise_edge_enable_r) != PIN_RST
    |-> (rise_det & ~rise_edge_enable_r) == PIN_RST)
    else $error("rise detected without enable");

  fall_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (~sync2_r & prev_r & ~fall_edge_enable_r) != PIN_RST
    |-> (fall_det & ~fall_edge_enable_r) == PIN_RST)
    else $error("fall detected without enable");

  both_edges_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rise_edge_enable_r & fall_edge_enable_r & (sync2_r ^ prev_r)) != PIN_RST
    |-> (rise_edge_enable_r & fall_edge_enable_r & (sync2_r ^ prev_r) & ~pin_change_detect) == PIN_RST)
    else $error("edge missed with both enables");

  both_excl_a: assert property (@(posedge clk_sys) disable iff (rst)
    rise_det != PIN_RST
    |-> (rise_det & fall_det) == PIN_RST)
    else $error("rise and fall on one pin at once");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_flags
    |=> ($past(pin_change_flags_r) & ~pin_change_flags_r) == PIN_RST)
    else $error("flag dropped without write");

  flag_src_all_a: assert property (@(posedge clk_sys) disable iff (rst)
    pin_change_flags_r != $past(pin_change_flags_r)
    |-> (pin_change_flags_r & ~$past(pin_change_flags_r) & ~$past(pin_change_detect)) == PIN_RST)
    else $error("flag set without detection");

  flag_set_all_a: assert property (@(posedge clk_sys) disable iff (rst)
    pin_change_detect != PIN_RST
    |=> (pin_change_flags_r & $past(pin_change_detect)) == $past(pin_change_detect))
    else $error("detection did not set flag");

  irq_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    cpu_irq
    == ($past(change_int_master_enable_r) && change_int_summary_flag))
    else $error("interrupt request not master and summary");

  flags_no_master_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!change_int_master_enable_r && pin_change_detect != PIN_RST)
    |=> change_int_summary_flag)
    else $error("flags stopped with master enable clear");

  summary_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && req.addr == OFS_INTCTL)
    |-> rdata[BIT_SUMMARY] == $past(|pin_change_flags_r))
    else $error("summary bit read wrong");

  zero_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_flags && pin_change_detect == PIN_RST)
    |=> pin_change_flags_r == ($past(pin_change_flags_r) & $past(req.wdata[NP-1:0])))
    else $error("flag write not an and");

  set_wins_all_a: assert property (@(posedge clk_sys) disable iff (rst)
    flag_write_s
    |=> (pin_change_flags_r & $past(pin_change_detect)) == $past(pin_change_detect))
    else $error("write lost a detected edge");

  wake_needs_sleep_a: assert property (@(posedge clk_sys) disable iff (rst)
    wake_up
    |-> $past(sleep_s2_r && change_int_master_enable_r))
    else $error("wake outside sleep or master enable");

  wake_reg_a: assert property (@(posedge clk_sys) disable iff (rst)
    wake_up
    |-> pin_change_flags_r != PIN_RST)
    else $error("wake with flag register empty");

  rd_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && req.addr == OFS_FLAGS)
    |-> rdata == pad($past(pin_change_flags_r)))
    else $error("flag register read wrong");

  rd_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && req.addr == OFS_RISE)
    |-> rdata == pad($past(rise_edge_enable_r)))
    else $error("rise enable read wrong");

  rd_fall_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.rd && req.addr == OFS_FALL)
    |-> rdata == pad($past(fall_edge_enable_r)))
    else $error("fall enable read wrong");

  rise_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.wr && req.addr == OFS_RISE)
    |-> rise_edge_enable_r == $past(req.wdata[NP-1:0]))
    else $error("rise enable write lost");

  fall_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(req.wr && req.addr == OFS_FALL)
    |-> fall_edge_enable_r == $past(req.wdata[NP-1:0]))
    else $error("fall enable write lost");

  sync_chain_a: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1
    |-> sync2_r == $past(sync1_r))
    else $error("synchroniser skipped a stage");

  prev_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1
    |-> prev_r == $past(sync2_r))
    else $error("previous sample not one cycle old");

  fall_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    fall_det != PIN_RST
    |=> (fall_det & $past(fall_det)) == PIN_RST)
    else $error("fall detection longer than one cycle");

  status_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev_now != EV_RST
    |=> (ev_status_r & $past(ev_now)) == $past(ev_now))
    else $error("event status lost a set");

  irq_out_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    irq_out
    |-> $past(ev_mask_r) != EV_RST)
    else $error("interrupt output with mask clear");

  rd_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(req.rd)
    |-> rdata == RD_ZERO)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// *** port_pin_change_interrupt_tb.sv ***
/*
  port_pin_change_interrupt_tb: self-checking bench for pcint_top.
  Assumes pcint_pkg offsets and the registered read data of the plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
module port_pin_change_interrupt_tb;
  import pcint_pkg::*;
  logic             clk_sys;
  logic             rst;
  logic             sleep_mode;
  pcint_req_t       req;
  logic [DW-1:0]    rdata;
  logic [NPINS-1:0] port_pins;
  logic             cpu_irq;
  logic             wake_up;
  logic             change_int_summary_flag;
  logic             irq_out;
  int               failures;
  int               samples_checked;

  pcint_top pcint_top_i (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .req                     (req),
    .rdata                   (rdata),
    .port_pins               (port_pins),
    .sleep_mode              (sleep_mode),
    .cpu_irq                 (cpu_irq),
    .wake_up                 (wake_up),
    .change_int_summary_flag (change_int_summary_flag),
    .irq_out                 (irq_out)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1 chk(nm, exp, rdata);
  endtask

  // pins are synchronised, so give each level several cycles to land
  task automatic pins(input logic [NPINS-1:0] v);
    @(posedge clk_sys);
    port_pins <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_regs;
    rd(OFS_FLAGS, 8'h00, "flags reset");
    wr(OFS_RISE, 8'hff);
    rd(OFS_RISE, 8'h3f, "rise enable");
    wr(OFS_FALL, 8'hc0);
    rd(OFS_FALL, 8'h00, "fall enable");
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00, "unmapped");
    $display("test regs done");
  endtask

  task automatic t_edges;
    wr(OFS_RISE, 8'h05);
    wr(OFS_FALL, 8'h06);
    pins(6'h3f);
    rd(OFS_FLAGS, 8'h05, "rise flags");
    chk("summary", 8'h01, {7'h0, change_int_summary_flag});
    chk("irq masked", 8'h00, {7'h0, cpu_irq});
    wr(OFS_INTCTL, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq on", 8'h01, {7'h0, cpu_irq});
    rd(OFS_INTCTL, 8'h03, "control read");
    wr(OFS_FLAGS, 8'h04);
    rd(OFS_FLAGS, 8'h04, "partial clear");
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h00, "clear");
    chk("summary off", 8'h00, {7'h0, change_int_summary_flag});
    chk("irq off", 8'h00, {7'h0, cpu_irq});
    pins(6'h00);
    rd(OFS_FLAGS, 8'h06, "fall flags");
    wr(OFS_FLAGS, 8'hf9);
    pins(6'h3f);
    rd(OFS_FLAGS, 8'h05, "both edges");
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_INTCTL, 8'h00);
    $display("test edges done");
  endtask

  task automatic t_sleep;
    wr(OFS_RISE, 8'h01);
    wr(OFS_FALL, 8'h00);
    wr(OFS_INTCTL, 8'h01);
    @(posedge clk_sys);
    sleep_mode <= 1'b1;
    pins(6'h00);
    chk("no wake", 8'h00, {7'h0, wake_up});
    pins(6'h01);
    chk("wake", 8'h01, {7'h0, wake_up});
    rd(OFS_FLAGS, 8'h01, "flags at wake");
    rd(OFS_IRQST, 8'h03, "wake event");
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
    wr(OFS_FLAGS, 8'h00);
    $display("test sleep done");
  endtask

  // flag write lands on the same edge as the detection
  task automatic t_race;
    pins(6'h00);
    @(posedge clk_sys);
    port_pins <= 6'h01;
    @(posedge clk_sys);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, OFS_FLAGS, 8'h00};
    @(posedge clk_sys);
    req <= '0;
    rd(OFS_FLAGS, 8'h01, "set wins");
    $display("test race done");
  endtask

  task automatic t_irq;
    wr(OFS_IRQST, 8'h03);
    rd(OFS_IRQST, 8'h00, "status clear");
    wr(OFS_IRQMSK, 8'h01);
    pins(6'h00);
    pins(6'h01);
    chk("irq out", 8'h01, {7'h0, irq_out});
    rd(OFS_IRQST, 8'h01, "status edge");
    wr(OFS_IRQMSK, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq masked", 8'h00, {7'h0, irq_out});
    wr(OFS_IRQST, 8'h01);
    rd(OFS_IRQST, 8'h00, "status w1c");
    $display("test irq done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    sleep_mode = 1'b0;
    req = '0;
    port_pins = 6'h00;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_edges();
    t_sleep();
    t_race();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
